// File: hw/pxm_port_ctrl.sv
// port 4/6 latches, expansion-mode register, key-wake logic and the external bus sequencer
// assumes a cpu issuing single-cycle memory-manipulation strobes on the same clock, and pins
// arriving asynchronously (synchronised here)
`include "pxm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pxm_port_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // cpu register access
  input wire pxm_pkg::pxm_cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  // cpu external access
  input wire logic ext_req_valid,
  input wire pxm_pkg::pxm_ext_req_t ext_req,
  input wire logic addr_internal,
  output logic ext_busy,
  output logic ext_done,
  output logic ext_refused,
  output logic [7:0] ext_rdata,
  // port 4 pins (muxed bus lines)
  input wire logic [7:0] port4_in,
  output logic [7:0] port4_out,
  output logic [7:0] port4_oe_n,
  // port 5 upper address lines
  output logic [7:0] upper_addr_lines,
  output logic [7:0] upper_addr_oe_n,
  // port 6 pins
  input wire logic [7:0] port6_in,
  output logic [7:0] port6_out,
  output logic [7:0] port6_oe_n,
  // standby release
  output logic key_wake_release
);

  // bus sequencer states
  typedef enum logic [2:0] {
    PXM_ST_IDLE,
    PXM_ST_ADDR,
    PXM_ST_STROBE,
    PXM_ST_DONE
  } pxm_state_t;

  // registers
  logic [7:0] exp_mode_reg, exp_mode_next; // expansion_mode_ctrl
  logic [7:0] key_wake_reg, key_wake_next; // key_wake_ctrl
  logic [7:0] p4_latch_reg, p4_latch_next; // port 4 output latch
  logic [7:0] p6_latch_reg, p6_latch_next; // port 6 output latch
  logic [7:0] p6_dir_reg, p6_dir_next; // port 6 direction, 1 = input
  // synchronisers: stage one is read only by stage two
  logic [7:0] p4_sync1_reg, p4_sync2_reg, p4_prev_reg;
  logic [7:0] p6_sync1_reg, p6_sync2_reg;
  // edge detection stays off until real pin samples reach the history stage;
  // the synchronisers reset high, so without this a low pin would look like a falling edge
  logic [2:0] p4_arm_reg;
  // bus sequencer
  pxm_state_t state_reg, state_next;
  pxm_pkg::pxm_ext_req_t bus_reg, bus_next; // captured external access
  logic [1:0] strobe_cnt_reg, strobe_cnt_next; // remaining strobe cycles
  logic [7:0] ext_rdata_next;

  // decoded mode fields
  wire [2:0] exp_sel = exp_mode_reg[`PXM_EXP_SEL_MSB:`PXM_EXP_SEL_LSB];
  wire [1:0] wait_sel = exp_mode_reg[`PXM_WAIT_SEL_MSB:`PXM_WAIT_SEL_LSB];
  wire bus_mode = exp_sel[1] | exp_sel[2];
  wire p4_output_mode = (exp_sel == pxm_pkg::PXM_SEL_PORT_OUT);
  wire wait_pin_mode = (wait_sel == pxm_pkg::PXM_WAIT_PIN);
  wire wait_pin_low = ~p6_sync2_reg[`PXM_P6_WAIT_BIT];

  // port 4 direction: all out or all in, the latch only matters outside bus mode
  // a change of direction reaches the pins one cycle after the mode write
  wire [7:0] p4_dir = p4_output_mode ? 8'h00 : 8'hFF;

  // value the cpu sees at an address; also the base of a bit operation
  function automatic logic [7:0] read_value(input logic [15:0] a);
    case (a)
      `PXM_ADDR_EXP_MODE: read_value = exp_mode_reg & `PXM_MASK_EXP_MODE;
      `PXM_ADDR_KEY_WAKE: read_value = key_wake_reg & `PXM_MASK_KEY_WAKE;
      // input pins read the pin, output pins the latch
      `PXM_ADDR_PORT4: read_value = (p4_sync2_reg & p4_dir) | (p4_latch_reg & ~p4_dir);
      `PXM_ADDR_PORT6: read_value = (p6_sync2_reg & p6_dir_reg) | (p6_latch_reg & ~p6_dir_reg);
      `PXM_ADDR_PORT6_DIR: read_value = p6_dir_reg;
      default: read_value = `PXM_RST_BYTE;
    endcase
  endfunction

  // write byte: a bit operation rewrites the whole 8-bit unit it read
  // so latch bits of input pins pick up the pin level, i.e. are not preserved
  wire [7:0] base_value = read_value(cpu_req.addr);
  wire [7:0] bit_mask = 8'h01 << cpu_req.bit_sel;
  wire [7:0] bit_result = cpu_req.bit_val ? (base_value | bit_mask) : (base_value & ~bit_mask);
  wire [7:0] wr_byte = cpu_req.bit_op ? bit_result : cpu_req.wdata;

  // write strobes per register
  wire wr_exp = cpu_req.wr & (cpu_req.addr == `PXM_ADDR_EXP_MODE);
  wire wr_key = cpu_req.wr & (cpu_req.addr == `PXM_ADDR_KEY_WAKE);
  wire wr_p4 = cpu_req.wr & (cpu_req.addr == `PXM_ADDR_PORT4);
  wire wr_p6 = cpu_req.wr & (cpu_req.addr == `PXM_ADDR_PORT6);
  wire wr_p6d = cpu_req.wr & (cpu_req.addr == `PXM_ADDR_PORT6_DIR);

  // any falling edge on port 4 pins, taken from settled samples once armed
  wire key_armed = &p4_arm_reg;
  wire key_edge = key_armed & (|(p4_prev_reg & ~p4_sync2_reg));

  // register next values
  always_comb begin
    // a bit operation arrives here already merged with the value it read
    // illegal codes are stored as written; software keeps them out
    exp_mode_next = wr_exp ? (wr_byte & `PXM_MASK_EXP_MODE) : exp_mode_reg;
    // latches change only on a write, whatever the direction
    p4_latch_next = wr_p4 ? wr_byte : p4_latch_reg;
    p6_latch_next = wr_p6 ? wr_byte : p6_latch_reg;
    p6_dir_next = wr_p6d ? wr_byte : p6_dir_reg;
    key_wake_next = wr_key ? (wr_byte & `PXM_MASK_KEY_WAKE) : key_wake_reg;
    // an edge in the clearing cycle wins; nothing else clears the flag
    if (key_edge) begin
      key_wake_next[`PXM_KEY_FLAG_BIT] = 1'b1;
    end
  end

  // external window: which areas leave the chip in each mode
  // internal areas never leave the chip, even in full-address mode
  wire ext_allowed = bus_mode & ~addr_internal;

  // bus sequencer next state
  always_comb begin
    state_next = state_reg;
    bus_next = bus_reg;
    strobe_cnt_next = strobe_cnt_reg;
    ext_rdata_next = ext_rdata;
    case (state_reg)
      PXM_ST_IDLE: begin
        // a refused request leaves the sequencer untouched; the refusal flag reports it
        if (ext_req_valid & ext_allowed) begin
          state_next = PXM_ST_ADDR;
          bus_next = ext_req;
        end
      end
      PXM_ST_ADDR: begin
        state_next = PXM_ST_STROBE;
        if (wait_pin_mode) begin
          // the wait pin reaches the sequencer through two flip-flops, so the strobe runs
          // long enough for a responder's wait to arrive before it is sampled
          strobe_cnt_next = `PXM_STROBE_PIN_WAIT;
        end else begin
          // one-wait adds a cycle; the prohibited code behaves as none
          strobe_cnt_next = (wait_sel == pxm_pkg::PXM_WAIT_ONE) ? `PXM_STROBE_ONE_WAIT
                                                                : `PXM_STROBE_BASE;
        end
      end
      PXM_ST_STROBE: begin
        if (strobe_cnt_reg > `PXM_STROBE_BASE) begin
          strobe_cnt_next = strobe_cnt_reg - `PXM_STROBE_BASE;
        end else if (wait_pin_mode & wait_pin_low) begin
          // stretched for as long as the wait pin is held low
          strobe_cnt_next = strobe_cnt_reg;
        end else begin
          state_next = PXM_ST_DONE;
          // read data is the synchronised bus and lags the pins by two cycles;
          // only the external-wait strobe, three cycles or longer, gives a responder's data time to arrive
          ext_rdata_next = p4_sync2_reg;
        end
      end
      PXM_ST_DONE: begin
        // one cycle at idle levels keeps the strobes of two accesses apart
        state_next = PXM_ST_IDLE;
      end
      default: begin
        state_next = PXM_ST_IDLE;
      end
    endcase
  end

  // pin drive values, all registered
  logic [7:0] p4_out_next, p4_oe_n_next, p5_out_next, p5_oe_n_next, p6_out_next, p6_oe_n_next;
  logic [7:0] p5_group;
  wire in_addr = (state_next == PXM_ST_ADDR);
  wire in_strobe = (state_next == PXM_ST_STROBE);

  // upper address group for the selected mode
  always_comb begin
    case (exp_sel)
      pxm_pkg::PXM_SEL_4K: p5_group = `PXM_P5_A8_11;
      pxm_pkg::PXM_SEL_16K: p5_group = `PXM_P5_A8_13;
      pxm_pkg::PXM_SEL_FULL: p5_group = `PXM_P5_A8_15;
      default: p5_group = `PXM_P5_NONE;
    endcase
  end

  // pin outputs; an enable low means the pin is driven
  always_comb begin
    // port mode: latch drives only output pins
    p4_out_next = p4_latch_next;
    p4_oe_n_next = p4_dir;
    if (bus_mode) begin
      // address during the strobe phase of the latch, write data after
      p4_out_next = in_addr ? bus_next.addr[7:0] : bus_next.wdata;
      p4_oe_n_next = (in_addr | (in_strobe & bus_next.wr)) ? 8'h00 : 8'hFF;
    end
    // upper lines follow the captured access; groups outside the mode stay undriven
    p5_out_next = bus_next.addr[15:8] & p5_group;
    p5_oe_n_next = ~p5_group;
    // low pins always follow their own latch and direction
    p6_out_next = p6_latch_next;
    p6_oe_n_next = p6_dir_next;
    if (bus_mode) begin
      // strobes active low, latch strobe active high
      p6_out_next[`PXM_P6_RD_BIT] = ~(in_strobe & ~bus_next.wr);
      p6_out_next[`PXM_P6_WR_BIT] = ~(in_strobe & bus_next.wr);
      p6_out_next[`PXM_P6_STB_BIT] = in_addr;
      p6_oe_n_next = p6_dir_next & ~`PXM_P6_BUS_PINS;
      p6_oe_n_next[`PXM_P6_WAIT_BIT] = 1'b1;
      // without external wait the wait pin is free for port use
      if (!wait_pin_mode) begin
        p6_out_next[`PXM_P6_WAIT_BIT] = p6_latch_next[`PXM_P6_WAIT_BIT];
        p6_oe_n_next[`PXM_P6_WAIT_BIT] = p6_dir_next[`PXM_P6_WAIT_BIT];
      end
    end
  end

  // control registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // single-chip with port 4 as input until software chooses otherwise
      exp_mode_reg <= `PXM_RST_EXP_MODE;
      key_wake_reg <= `PXM_RST_KEY_WAKE;
      p4_latch_reg <= `PXM_RST_LATCH;
      p6_latch_reg <= `PXM_RST_LATCH;
      p6_dir_reg <= `PXM_RST_DIR;
    end else begin
      exp_mode_reg <= exp_mode_next;
      key_wake_reg <= key_wake_next;
      p4_latch_reg <= p4_latch_next;
      p6_latch_reg <= p6_latch_next;
      p6_dir_reg <= p6_dir_next;
    end
  end

  // pin synchronisers and edge history
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      p4_sync1_reg <= `PXM_RST_DIR;
      p4_sync2_reg <= `PXM_RST_DIR;
      p4_prev_reg <= `PXM_RST_DIR;
      p6_sync1_reg <= `PXM_RST_DIR;
      p6_sync2_reg <= `PXM_RST_DIR;
      p4_arm_reg <= '0;
    end else begin
      p4_sync1_reg <= port4_in;
      p4_sync2_reg <= p4_sync1_reg;
      p4_prev_reg <= p4_sync2_reg;
      p6_sync1_reg <= port6_in;
      p6_sync2_reg <= p6_sync1_reg;
      // arming shifts in ones and then stays set
      p4_arm_reg <= {p4_arm_reg[1:0], 1'b1};
    end
  end

  // bus sequencer registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= PXM_ST_IDLE;
      bus_reg <= '0;
      // the counter rests at its base length between accesses
      strobe_cnt_reg <= `PXM_STROBE_BASE;
      ext_rdata <= `PXM_RST_BYTE;
    end else begin
      state_reg <= state_next;
      bus_reg <= bus_next;
      strobe_cnt_reg <= strobe_cnt_next;
      ext_rdata <= ext_rdata_next;
    end
  end

  // cpu answers and bus status
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rdata <= `PXM_RST_BYTE;
      cpu_rvalid <= 1'b0;
      ext_busy <= 1'b0;
      ext_done <= 1'b0;
      ext_refused <= 1'b0;
    end else begin
      // a read answer stands one cycle; the data holds until the next read
      cpu_rdata <= cpu_req.rd ? base_value : cpu_rdata;
      cpu_rvalid <= cpu_req.rd;
      ext_busy <= (state_next != PXM_ST_IDLE);
      ext_done <= (state_next == PXM_ST_DONE);
      // requests outside the external window, or while busy, are dropped
      ext_refused <= ext_req_valid & ((state_reg != PXM_ST_IDLE) | ~ext_allowed);
    end
  end

  // pin registers; port 6 resets to inputs, port 4 to inputs per the reset mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port4_out <= `PXM_RST_LATCH;
      port4_oe_n <= `PXM_RST_DIR;
      upper_addr_lines <= `PXM_RST_LATCH;
      upper_addr_oe_n <= `PXM_RST_DIR;
      port6_out <= `PXM_RST_LATCH;
      port6_oe_n <= `PXM_RST_DIR;
      key_wake_release <= 1'b0;
    end else begin
      port4_out <= p4_out_next;
      port4_oe_n <= p4_oe_n_next;
      upper_addr_lines <= p5_out_next;
      upper_addr_oe_n <= p5_oe_n_next;
      port6_out <= p6_out_next;
      port6_oe_n <= p6_oe_n_next;
      // release held while the flag is set and not masked
      key_wake_release <= key_wake_next[`PXM_KEY_FLAG_BIT] & ~key_wake_next[`PXM_KEY_MASK_BIT];
    end
  end

endmodule

`default_nettype wire

// File: common/pxm_cfg.svh
// constants for the port latch and expansion-mode block: offsets, reset values, field positions
// assumes an 8-bit cpu data path and a 16-bit address space
`ifndef PXM_CFG_SVH
`define PXM_CFG_SVH

// register addresses in the cpu address space
`define PXM_ADDR_EXP_MODE 16'hFFF8
`define PXM_ADDR_KEY_WAKE 16'hFFF6
`define PXM_ADDR_PORT4 16'hFF04
`define PXM_ADDR_PORT6 16'hFF06
`define PXM_ADDR_PORT6_DIR 16'hFF26

// reset values
`define PXM_RST_EXP_MODE 8'h10
`define PXM_RST_KEY_WAKE 8'h02
`define PXM_RST_LATCH 8'h00
`define PXM_RST_DIR 8'hFF
`define PXM_RST_BYTE 8'h00

// writable bits of the expansion-mode and key-wake registers
`define PXM_MASK_EXP_MODE 8'h37
`define PXM_MASK_KEY_WAKE 8'h03

// expansion-mode field positions
`define PXM_EXP_SEL_LSB 0
`define PXM_EXP_SEL_MSB 2
`define PXM_WAIT_SEL_LSB 4
`define PXM_WAIT_SEL_MSB 5

// key-wake field positions
`define PXM_KEY_FLAG_BIT 0
`define PXM_KEY_MASK_BIT 1

// port 6 upper pin positions used by the external bus
`define PXM_P6_RD_BIT 4
`define PXM_P6_WR_BIT 5
`define PXM_P6_WAIT_BIT 6
`define PXM_P6_STB_BIT 7
`define PXM_P6_BUS_PINS 8'hF0

// upper address line groups carried on port 5
`define PXM_P5_A8_11 8'h0F
`define PXM_P5_A8_13 8'h3F
`define PXM_P5_A8_15 8'hFF
`define PXM_P5_NONE 8'h00

// strobe base length, the strobe length for the one-wait setting, and the length that covers
// the wait pin's two synchroniser stages in external-wait mode
`define PXM_STROBE_BASE 2'h1
`define PXM_STROBE_ONE_WAIT 2'h2
`define PXM_STROBE_PIN_WAIT 2'h3

`endif

// File: common/pxm_pkg.sv
// types shared by the port latch and expansion-mode block
// assumes pxm_cfg.svh supplies the numeric constants
package pxm_pkg;

  // expansion select codes
  typedef enum logic [2:0] {
    PXM_SEL_PORT_IN = 3'h0,
    PXM_SEL_PORT_OUT = 3'h1,
    PXM_SEL_BUS = 3'h3,
    PXM_SEL_4K = 3'h4,
    PXM_SEL_16K = 3'h5,
    PXM_SEL_FULL = 3'h7
  } pxm_exp_sel_t;

  // wait select codes
  typedef enum logic [1:0] {
    PXM_WAIT_NONE = 2'h0,
    PXM_WAIT_ONE = 2'h1,
    PXM_WAIT_BAD = 2'h2,
    PXM_WAIT_PIN = 2'h3
  } pxm_wait_sel_t;

  // one cpu memory-manipulation access
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bit_op;
    logic [2:0] bit_sel;
    logic bit_val;
  } pxm_cpu_req_t;

  // one external bus access
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
  } pxm_ext_req_t;

endpackage

// File: testbench/pxm_assertions.sv
// checker for the port latch and expansion-mode block
// assumes a bind onto pxm_port_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pxm_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // cpu side
  input wire pxm_pkg::pxm_cpu_req_t cpu_req,
  input wire logic cpu_rvalid,
  input wire logic ext_req_valid,
  input wire logic ext_busy,
  input wire logic ext_done,
  input wire logic ext_refused,
  // pins
  input wire logic [7:0] port4_oe_n,
  input wire logic [7:0] port6_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  rd_answer_a: assert property (cpu_req.rd |=> cpu_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (cpu_rvalid |-> $past(cpu_req.rd))
    else $error("stray read valid");
  p4_input_rst_a: assert property ($rose(reset_n) |-> port4_oe_n == 8'hFF)
    else $error("port 4 not input after reset");
  p4_dir_whole_a: assert property (port4_oe_n == 8'hFF || port4_oe_n == 8'h00)
    else $error("port 4 split direction");
  ext_taken_a: assert property (ext_req_valid && !ext_busy |=> ext_busy || ext_refused)
    else $error("request neither taken nor refused");
  busy_min_a: assert property ($rose(ext_busy) |-> (port6_out[7] && ext_busy) ##1 ext_busy [*2])
    else $error("access too short");
  done_bound_a: assert property ($rose(ext_busy) |-> ##[2:60] ext_done)
    else $error("access never finished");
  done_idle_a: assert property (ext_done |-> port6_out[4] && port6_out[5] ##1 !ext_busy)
    else $error("strobe still active at end");
  c_ext: cover property (ext_done);
  c_ref: cover property (ext_refused);
  c_rd: cover property (cpu_rvalid);
endmodule
bind pxm_port_ctrl pxm_assertions pxm_assertions_i (.clock, .reset_n, .cpu_req, .cpu_rvalid,
  .ext_req_valid, .ext_busy, .ext_done, .ext_refused, .port4_oe_n, .port6_out);
`default_nettype wire

// File: testbench/pxm_ext_mem.sv
// external memory on the muxed bus, plus the bench-driven pin levels
// assumes active-low read/write strobes and an active-high latch strobe
`timescale 1ns/1ps
`default_nettype none
module pxm_ext_mem (
  // clock and block pins
  input wire logic clock,
  input wire logic [7:0] port4_out,
  input wire logic [7:0] port4_oe_n,
  input wire logic [7:0] port6_out,
  input wire logic [7:0] port6_oe_n,
  // bench levels and wait length
  input wire logic [7:0] pin4,
  input wire logic [7:0] pin6,
  input wire logic [3:0] stall,
  // pins into the block
  output logic [7:0] port4_in,
  output logic [7:0] port6_in
);
  logic [7:0] mem [256];
  logic [7:0] lo;
  logic [3:0] cnt;
  wire logic rd_n = port6_oe_n[4] | port6_out[4];
  wire logic wr_n = port6_oe_n[5] | port6_out[5];
  wire logic wt = !(rd_n && wr_n) && cnt != 4'h0;
  // address byte caught while the latch strobe is high
  always @(posedge clock) begin
    if (!port6_oe_n[7] && port6_out[7]) lo <= port4_out;
    if (!wr_n) mem[lo] <= port4_out;
    cnt <= (rd_n && wr_n) ? stall : cnt - {3'h0, wt};
  end
  // read data only while the read strobe is low; otherwise bench level, or the block's own value while it drives port 4
  assign port4_in = !rd_n ? mem[lo] : (&port4_oe_n ? pin4 : port4_out);
  always_comb begin
    port6_in = (port6_out & ~port6_oe_n) | (pin6 & port6_oe_n);
    if (wt) port6_in[6] = 1'b0;
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// bench for pxm_port_ctrl with the external memory model
// assumes pxm_pkg is compiled first
`include "pxm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] EM = `PXM_ADDR_EXP_MODE;
  localparam logic [15:0] KW = `PXM_ADDR_KEY_WAKE;
  localparam logic [15:0] P4 = `PXM_ADDR_PORT4;
  localparam logic [15:0] P6 = `PXM_ADDR_PORT6;
  localparam logic [15:0] D6 = `PXM_ADDR_PORT6_DIR;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  pxm_pkg::pxm_cpu_req_t cpu_req = '0;
  pxm_pkg::pxm_ext_req_t ext_req = '0;
  logic ext_req_valid = 1'b0;
  logic addr_internal = 1'b0;
  logic [7:0] pin4 = 8'h5A;
  logic [7:0] pin6 = 8'hE0; // wait pin idles high
  logic [3:0] stall = 4'h0;
  logic [7:0] cpu_rdata, ext_rdata, port4_in, port4_out, port4_oe_n, up_l, up_oe_n;
  logic [7:0] port6_in, port6_out, port6_oe_n, v;
  logic cpu_rvalid, ext_busy, ext_done, ext_refused, key_wake_release;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  always #5 clock = ~clock;
  pxm_port_ctrl pxm_port_ctrl_i (.clock, .reset_n, .cpu_req, .cpu_rdata, .cpu_rvalid,
    .ext_req_valid, .ext_req, .addr_internal, .ext_busy, .ext_done, .ext_refused, .ext_rdata,
    .port4_in, .port4_out, .port4_oe_n, .upper_addr_lines(up_l), .upper_addr_oe_n(up_oe_n),
    .port6_in, .port6_out, .port6_oe_n, .key_wake_release);
  pxm_ext_mem pxm_ext_mem_i (.clock, .port4_out, .port4_oe_n, .port6_out, .port6_oe_n,
    .pin4, .pin6, .stall, .port4_in, .port6_in);
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // b is bit_op, bit_sel, bit_val
  task automatic w(input logic [15:0] a, input logic [7:0] d, input logic [4:0] b = 5'h00);
    @(posedge clock);
    cpu_req <= {a, d, 1'b1, 1'b0, b};
    @(posedge clock);
    cpu_req <= '0;
    #1;
  endtask
  task automatic r(input logic [15:0] a);
    @(posedge clock);
    cpu_req <= {a, 8'h00, 1'b0, 1'b1, 5'h00};
    @(posedge clock);
    cpu_req <= '0;
    #1;
    v = cpu_rdata;
  endtask
  // one external access; n counts cycles to done or refusal
  task automatic ext(input logic [15:0] a, input logic [7:0] d, input logic wr,
                     input logic [7:0] m, input logic ai = 1'b0);
    @(posedge clock);
    ext_req_valid <= 1'b1;
    ext_req <= {a, d, wr};
    addr_internal <= ai;
    @(posedge clock);
    ext_req_valid <= 1'b0;
    #1;
    n = 1;
    chk("up_oe", ~up_oe_n, m);
    chk("up_addr", up_l & m, a[15:8] & m);
    while (!ext_done && !ext_refused && n < 60) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  task automatic t_reg;
    r(EM);
    chk("em_rst", v, 8'h10);
    r(KW);
    chk("kw_rst", v, 8'h02);
    w(EM, 8'h01);
    w(P4, 8'hA5);
    chk("p4_oe", port4_oe_n, 8'h00);
    chk("p4_out", port4_out, 8'hA5);
    r(P4);
    chk("p4_rd", v, 8'hA5);
    w(EM, 8'h00, 5'h10);
    r(EM);
    chk("em_bit", v, 8'h00);
    chk("p4_oe_in", port4_oe_n, 8'hFF);
    w(P4, 8'h3C);
    r(P4);
    chk("p4_pin", v, 8'h5A);
    w(EM, 8'h00, 5'h11);
    chk("p4_held", port4_out, 8'h3C);
  endtask
  task automatic t_port6;
    w(D6, 8'hF0);
    w(P6, 8'h00);
    w(P6, 8'h00, 5'h13);
    chk("p6_oe", port6_oe_n, 8'hF0);
    w(D6, 8'h00);
    chk("p6_rmw", port6_out, 8'hE2);
    w(EM, 8'h07);
    chk("p6_low", {port6_oe_n[3:0], port6_out[3:0]}, 8'h02);
    w(D6, 8'hF0);
  endtask
  task automatic t_ext;
    logic [2:0] c [4] = '{3'h3, 3'h4, 3'h5, 3'h7};
    logic [7:0] m [4] = '{8'h00, 8'h0F, 8'h3F, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      w(EM, {5'h00, c[i]});
      ext({8'hC5, 5'h00, c[i]}, 8'h60 + 8'(i), 1'b1, m[i]);
      chk("wait0", 8'(n), 8'h03);
    end
    w(EM, 8'h17);
    ext(16'hC503, 8'h00, 1'b0, 8'hFF);
    chk("wait1", 8'(n), 8'h04);
    stall = 4'h6;
    w(EM, 8'h37);
    ext(16'hC507, 8'h00, 1'b0, 8'hFF);
    chk("waitpin", 8'(n > 5), 8'h01);
    chk("ext_rd", ext_rdata, 8'h63);
    ext(16'hC500, 8'h00, 1'b0, 8'hFF, 1'b1);
    chk("ref_int", 8'(n), 8'h01);
    w(EM, 8'h00);
    ext(16'hC500, 8'h00, 1'b0, 8'h00);
    chk("ref_port", 8'(n), 8'h01);
  endtask
  task automatic t_key;
    w(KW, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    chk("kw_clr", 8'(key_wake_release), 8'h00);
    @(posedge clock);
    pin4 <= 8'h00;
    repeat (6) @(posedge clock);
    #1;
    chk("kw_set", 8'(key_wake_release), 8'h01);
    repeat (20) @(posedge clock);
    r(KW);
    chk("kw_stick", v, 8'h01);
    w(KW, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    chk("kw_off", 8'(key_wake_release), 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    t_reg;
    t_port6;
    t_ext;
    t_key;
    give_verdict;
  end
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict;
    end
  end
endmodule
`default_nettype wire
